// >>> pkg/smbsp_pkg.sv
package smbsp_pkg;
  localparam logic [6:0] SLAVE_ADDR     = 7'h4C;  // 1001_100
  localparam logic [6:0] ARA_ADDR       = 7'h0C;  // 0001_100
  localparam int         CLK_MHZ        = 100;
  localparam int         POWERUP_MS     = 15;
  localparam int         TIMEOUT_MS     = 30;
  localparam int         POWERUP_CYCLES = POWERUP_MS * 1000 * CLK_MHZ;
  localparam int         TIMEOUT_CYCLES = TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam logic [7:0] PTR_RESET      = 8'h00;

  // register access towards the sensor's register file
  typedef struct packed {
    logic       wr_stb;
    logic [7:0] addr;
    logic [7:0] data;
  } smbsp_reg_wr_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } smbsp_bus_t;
endpackage : smbsp_pkg

// >>> core/smbsp_sync.sv
`timescale 1ns/100ps
// two-flop synchroniser plus edge detect on the second stage only
module smbsp_sync #(
  parameter int W = 2
) (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1_q <= {W{1'b1}};
      s2_q <= {W{1'b1}};
      s3_q <= {W{1'b1}};
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign dout = s2_q;
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;
endmodule : smbsp_sync

// >>> core/smbsp_port.sv
`timescale 1ns/100ps
// Operation
// - ignore all bus traffic for the first 15 ms after reset.
// - accept only send, read, write, receive byte and alert response query.
// - foreign address or bad protocol: stay silent, registers untouched.
// - tolerate stretched clock lows without losing protocol state.
// - write byte: ack address, pointer and data, then store data.
// - read byte: pointer write, repeated start, return one byte.
// - send byte: load pointer from single byte, no data write.
// - receive byte returns register at pointer, pointer never advances.
// - alert query answered with own address byte while alert pending.
// - set mask only after whole address byte sent without lost arbitration.
// - query never clears status; cleared mask with flags re-asserts alert.
// - with timeout enabled, clock low over 30 ms resets protocol to idle.
// - respond only to one fixed hard-wired slave address, plus the alert response address while alert pending.
// - alert output usable as plain interrupt or bus alert.
module smbsp_port #(
  parameter int POWERUP_CYCLES = smbsp_pkg::POWERUP_CYCLES,
  parameter int TIMEOUT_CYCLES = smbsp_pkg::TIMEOUT_CYCLES
) (
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire smbsp_pkg::smbsp_bus_t  bus_in,
  output smbsp_pkg::smbsp_bus_t       bus_oe_n,
  input  wire logic [7:0]             reg_rd_data,
  output smbsp_pkg::smbsp_reg_wr_t    reg_wr,
  output logic [7:0]                  reg_ptr,
  input  wire logic                   status_any,
  input  wire logic                   mask_clr,
  input  wire logic                   timeout_en,
  output logic                        alert_mask,
  output logic                        alert_n
);
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_ADDR = 7'b0000010,
    ST_AACK = 7'b0000100,
    ST_RXB  = 7'b0001000,
    ST_RACK = 7'b0010000,
    ST_TXB  = 7'b0100000,
    ST_TACK = 7'b1000000
  } smbsp_state_t;

  smbsp_state_t st_q;
  logic [1:0]   bus_s;
  logic [1:0]   bus_r;
  logic [1:0]   bus_f;
  logic         scl;
  logic         sda;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_ev;
  logic         stop_ev;
  logic [7:0]   sh_q;
  logic [2:0]   bit_q;
  logic [1:0]   byte_q;
  logic         byte_done_q;
  logic         ara_q;
  logic         lost_q;
  logic         sda_oe_n_q;
  logic         ready_q;
  logic [31:0]  pu_cnt_q;
  logic [31:0]  to_cnt_q;
  logic         to_hit;
  logic [7:0]   data_q;
  logic         data_v_q;
  logic [7:0]   ptr_q;
  logic         mask_q;

  smbsp_sync #(.W(2)) u_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .din     ({bus_in.scl, bus_in.sda}),
    .dout    (bus_s),
    .rise    (bus_r),
    .fall    (bus_f)
  );

  // edges are found on sampled levels, so a stretched low just waits
  assign scl      = bus_s[1];
  assign sda      = bus_s[0];
  assign scl_rise = bus_r[1];
  assign scl_fall = bus_f[1];
  assign start_ev = scl && bus_f[0] && ready_q;
  assign stop_ev  = scl && bus_r[0];
  assign to_hit   = timeout_en && (to_cnt_q >= TIMEOUT_CYCLES - 1);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pu_cnt_q <= 32'h0000_0000;
      ready_q  <= 1'b0;
    end else if (!ready_q) begin
      pu_cnt_q <= pu_cnt_q + 32'h0000_0001;
      ready_q  <= (pu_cnt_q >= POWERUP_CYCLES - 1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || scl) begin
      to_cnt_q <= 32'h0000_0000;
    end else if (!to_hit) begin
      to_cnt_q <= to_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || to_hit || stop_ev) begin
      st_q        <= ST_IDLE;
      sda_oe_n_q  <= 1'b1;
      bit_q       <= 3'h0;
      byte_q      <= 2'h0;
      byte_done_q <= 1'b0;
      ara_q       <= 1'b0;
      lost_q      <= 1'b0;
      data_v_q    <= 1'b0;
      // the pointer survives stop and timeout, only reset clears it
      if (reset) begin
        ptr_q <= smbsp_pkg::PTR_RESET;
      end
    end else if (start_ev) begin
      // also serves the repeated start of a read byte
      st_q       <= ST_ADDR;
      byte_done_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
      bit_q      <= 3'h0;
      byte_q     <= 2'h0;
      ara_q      <= 1'b0;
      lost_q     <= 1'b0;
      data_v_q   <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          sda_oe_n_q <= 1'b1;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            sh_q        <= {sh_q[6:0], sda};
            bit_q       <= bit_q + 3'h1;
            byte_done_q <= (bit_q == 3'h7);
          end else if (scl_fall && byte_done_q) begin
            // the fall just after start must not pass for a full byte
            byte_done_q <= 1'b0;
            if (sh_q[7:1] == smbsp_pkg::SLAVE_ADDR) begin
              st_q       <= ST_AACK;
              sda_oe_n_q <= 1'b0;
            end else if (sh_q[7:1] == smbsp_pkg::ARA_ADDR && sh_q[0]
                         && status_any && mask_q == 1'b0) begin
              st_q       <= ST_AACK;
              ara_q      <= 1'b1;
              sda_oe_n_q <= 1'b0;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            if (sh_q[0]) begin
              // read direction: load first data bit, pointer untouched
              st_q       <= ST_TXB;
              sh_q       <= ara_q ? {smbsp_pkg::SLAVE_ADDR, 1'b0} : reg_rd_data;
              sda_oe_n_q <= ara_q ? smbsp_pkg::SLAVE_ADDR[6] : reg_rd_data[7];
              bit_q      <= 3'h0;
            end else begin
              st_q       <= ST_RXB;
              sda_oe_n_q <= 1'b1;
            end
          end
        end
        ST_RXB: begin
          if (scl_rise) begin
            sh_q        <= {sh_q[6:0], sda};
            bit_q       <= bit_q + 3'h1;
            byte_done_q <= (bit_q == 3'h7);
          end else if (scl_fall && byte_done_q) begin
            byte_done_q <= 1'b0;
            if (byte_q < 2'h2) begin
              st_q       <= ST_RACK;
              sda_oe_n_q <= 1'b0;
              if (byte_q == 2'h0) begin
                ptr_q <= sh_q;
              end else begin
                data_q   <= sh_q;
                data_v_q <= 1'b1;
              end
              byte_q <= byte_q + 2'h1;
            end else begin
              // a third byte voids the pending data, so the stop writes nothing
              st_q     <= ST_IDLE;
              data_v_q <= 1'b0;
            end
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            st_q       <= ST_RXB;
            sda_oe_n_q <= 1'b1;
          end
        end
        ST_TXB: begin
          if (scl_rise) begin
            // a one we release but read low means another driver won
            if (sda_oe_n_q && !sda) begin
              lost_q <= 1'b1;
            end
            bit_q <= bit_q + 3'h1;
          end else if (scl_fall) begin
            if (lost_q) begin
              st_q       <= ST_IDLE;
              sda_oe_n_q <= 1'b1;
            end else if (bit_q == 3'h0) begin
              st_q       <= ST_TACK;
              sda_oe_n_q <= 1'b1;
            end else begin
              sh_q       <= {sh_q[6:0], 1'b0};
              sda_oe_n_q <= sh_q[6];
            end
          end
        end
        ST_TACK: begin
          if (scl_fall) begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // register write only at stop, so an aborted transfer leaves registers alone
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_wr <= '0;
    end else begin
      reg_wr.wr_stb <= stop_ev && data_v_q && byte_q == 2'h2 && !to_hit;
      reg_wr.addr   <= ptr_q;
      reg_wr.data   <= data_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mask_q <= 1'b0;
    end else if (st_q == ST_TACK && ara_q && scl_fall && !lost_q) begin
      mask_q <= 1'b1;
    end else if (mask_clr) begin
      mask_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      alert_n    <= 1'b1;
      alert_mask <= 1'b0;
      reg_ptr    <= smbsp_pkg::PTR_RESET;
      bus_oe_n   <= '1;
    end else begin
      // status is never cleared here, so unmasking re-raises the alert
      alert_n      <= !(status_any && !mask_q && ready_q);
      alert_mask   <= mask_q;
      reg_ptr      <= ptr_q;
      bus_oe_n.scl <= 1'b1;
      bus_oe_n.sda <= sda_oe_n_q;
    end
  end
endmodule : smbsp_port

// >>> tb/smbsp_host.sv
`timescale 1ns/100ps
module smbsp_host (
  input  wire logic sda_line,
  output logic      scl_host,
  output logic      sda_host
);
  real lo_ns = 62.5;
  initial begin
    scl_host = 1'b1;
    sda_host = 1'b1;
  end
  // data moves mid-low, so it never changes near a clock edge
  task automatic bit_io(input logic b, output logic r);
    #(lo_ns / 2) sda_host = b;
    #(lo_ns / 2) scl_host = 1'b1;
    #31 r = sda_line;
    #31.5 scl_host = 1'b0;
  endtask : bit_io
  task automatic start;
    #30 sda_host = 1'b1;
    #30 scl_host = 1'b1;
    #60 sda_host = 1'b0;
    #60 scl_host = 1'b0;
  endtask : start
  task automatic stop;
    #30 sda_host = 1'b0;
    #30 scl_host = 1'b1;
    #60 sda_host = 1'b1;
    #300;
  endtask : stop
  // byte then acknowledge slot, msb first
  task automatic xbyte(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) bit_io(d[i], q[i]);
  endtask : xbyte
endmodule : smbsp_host

// >>> tb/smbsp_port_asserts.sv
`timescale 1ns/100ps
module smbsp_port_asserts #(
  parameter int POWERUP_CYCLES = 50,
  parameter int TIMEOUT_CYCLES = 200
) (
  input wire logic                     ref_clk,
  input wire logic                     reset,
  input wire smbsp_pkg::smbsp_bus_t    bus_in,
  input wire smbsp_pkg::smbsp_bus_t    bus_oe_n,
  input wire smbsp_pkg::smbsp_reg_wr_t reg_wr,
  input wire logic [7:0]               reg_ptr,
  input wire logic                     status_any,
  input wire logic                     mask_clr,
  input wire logic                     timeout_en,
  input wire logic                     alert_mask,
  input wire logic                     alert_n
);
  int up_q;
  int low_q;
  always_ff @(posedge ref_clk) begin
    if (reset) up_q <= 0;
    else if (up_q < POWERUP_CYCLES) up_q <= up_q + 1;
  end
  // raw line count; margin covers the synchroniser delay
  always_ff @(posedge ref_clk) begin
    if (reset || bus_in.scl || !timeout_en) low_q <= 0;
    else if (low_q < TIMEOUT_CYCLES + 20) low_q <= low_q + 1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence unmasked_s;
    status_any && !alert_mask;
  endsequence
  scl_free_a: assert property (bus_oe_n.scl)
    else $error("clock line pulled");
  powerup_quiet_a: assert property (up_q < POWERUP_CYCLES |-> bus_oe_n.sda)
    else $error("data line pulled in power-up");
  timeout_idle_a: assert property (low_q == TIMEOUT_CYCLES + 20 |-> bus_oe_n.sda)
    else $error("data line held after timeout");
  wr_pulse_a: assert property (reg_wr.wr_stb |=> !reg_wr.wr_stb)
    else $error("write strobe too long");
  wr_ptr_a: assert property (reg_wr.wr_stb |-> reg_wr.addr == reg_ptr)
    else $error("write address not pointer");
  alert_on_a: assert property (unmasked_s ##1 unmasked_s |-> !alert_n)
    else $error("alert missing");
  mask_fall_a: assert property ($fell(alert_mask) |-> $past(mask_clr, 2))
    else $error("mask cleared by itself");
  mask_rise_a: assert property ($rose(alert_mask) |-> $past(alert_n) == 1'b0)
    else $error("mask set without alert");
endmodule : smbsp_port_asserts

// >>> tb/smbus_slave_register_port_bench.sv
`timescale 1ns/100ps
module smbus_slave_register_port_bench;
  logic                     ref_clk = 1'b0;
  logic                     reset = 1'b1;
  smbsp_pkg::smbsp_bus_t    bus_in;
  smbsp_pkg::smbsp_bus_t    bus_oe_n;
  smbsp_pkg::smbsp_reg_wr_t reg_wr;
  smbsp_pkg::smbsp_reg_wr_t wr_last;
  logic [7:0]               reg_ptr;
  logic [7:0]               reg_rd_data;
  logic                     status_any = 1'b0;
  logic                     mask_clr = 1'b0;
  logic                     timeout_en = 1'b1;
  logic                     alert_mask;
  logic                     alert_n;
  logic                     scl_host;
  logic                     sda_host;
  logic [8:0]               q;
  int                       fail_count = 0;
  int                       total_checks = 0;
  int                       wr_count = 0;
  int                       cyc = 0;
  always #5 ref_clk = ~ref_clk;
  // pulled-up lines: low when either side pulls
  assign bus_in.scl = scl_host & bus_oe_n.scl;
  assign bus_in.sda = sda_host & bus_oe_n.sda;
  assign reg_rd_data = reg_ptr ^ 8'h3C;
  smbsp_port #(.POWERUP_CYCLES(50), .TIMEOUT_CYCLES(200)) smbsp_port_inst (.ref_clk, .reset,
    .bus_in, .bus_oe_n, .reg_rd_data, .reg_wr, .reg_ptr, .status_any, .mask_clr, .timeout_en,
    .alert_mask, .alert_n);
  smbsp_host smbsp_host_inst (.sda_line(bus_in.sda), .scl_host, .sda_host);
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (reg_wr.wr_stb) begin
      wr_count <= wr_count + 1;
      wr_last <= reg_wr;
    end
    if (cyc == 40000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wbyte(input logic [7:0] b, input logic ak);
    smbsp_host_inst.xbyte({b, 1'b1}, q);
    chk("ack", {7'h00, q[0]}, {7'h00, ak});
  endtask : wbyte
  task automatic rbyte(input logic [7:0] exp);
    smbsp_host_inst.xbyte(9'h1FF, q);
    chk("read", q[8:1], exp);
  endtask : rbyte
  task automatic frame(input logic [7:0] a, input logic [7:0] b, input logic ak);
    smbsp_host_inst.start();
    wbyte(a, ak);
    wbyte(b, ak);
  endtask : frame
  task automatic t_write;
    smbsp_host_inst.lo_ns = 1500.0; // stretched, yet under the timeout
    frame({smbsp_pkg::SLAVE_ADDR, 1'b0}, 8'h12, 1'b0);
    wbyte(8'hA5, 1'b0);
    smbsp_host_inst.lo_ns = 62.5;
    smbsp_host_inst.stop();
    chk("wr addr", wr_last.addr, 8'h12);
    chk("wr data", wr_last.data, 8'hA5);
    $display("write done");
  endtask : t_write
  task automatic t_read;
    frame({smbsp_pkg::SLAVE_ADDR, 1'b0}, 8'h07, 1'b0);
    for (int i = 0; i < 3; i++) begin
      smbsp_host_inst.start();
      wbyte({smbsp_pkg::SLAVE_ADDR, 1'b1}, 1'b0);
      rbyte(8'h07 ^ 8'h3C);
      smbsp_host_inst.stop();
    end
    frame({smbsp_pkg::SLAVE_ADDR, 1'b0}, 8'h21, 1'b0);
    smbsp_host_inst.stop();
    chk("ptr", reg_ptr, 8'h21);
    frame({smbsp_pkg::SLAVE_ADDR, 1'b0}, 8'h30, 1'b0);
    wbyte(8'h55, 1'b0);
    wbyte(8'h66, 1'b1);
    smbsp_host_inst.stop();
    frame({smbsp_pkg::SLAVE_ADDR ^ 7'h01, 1'b0}, 8'h44, 1'b1);
    smbsp_host_inst.stop();
    chk("writes", 8'(wr_count), 8'h01);
    chk("ptr", reg_ptr, 8'h30);
    $display("read done");
  endtask : t_read
  task automatic t_alert;
    @(posedge ref_clk) #1 status_any = 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("alert", {7'h00, alert_n}, 8'h00);
    for (int i = 0; i < 2; i++) begin
      smbsp_host_inst.start();
      wbyte({smbsp_pkg::ARA_ADDR, 1'b1}, i[0]);
      if (i == 0) rbyte({smbsp_pkg::SLAVE_ADDR, 1'b0});
      smbsp_host_inst.stop();
      chk("alert", {6'h00, alert_mask, alert_n}, 8'h03);
    end
    @(posedge ref_clk) #1 mask_clr = 1'b1;
    @(posedge ref_clk) #1 mask_clr = 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("alert", {6'h00, alert_mask, alert_n}, 8'h00);
    $display("alert done");
  endtask : t_alert
  task automatic t_timeout;
    smbsp_host_inst.start();
    wbyte({smbsp_pkg::SLAVE_ADDR, 1'b0}, 1'b0);
    repeat (300) @(posedge ref_clk);
    chk("release", {7'h00, bus_oe_n.sda}, 8'h01);
    // after the timeout the port is idle and must not ack the rest of the frame
    wbyte(8'h5A, 1'b1);
    smbsp_host_inst.stop();
    frame({smbsp_pkg::SLAVE_ADDR, 1'b0}, 8'h33, 1'b0);
    smbsp_host_inst.stop();
    chk("ptr", reg_ptr, 8'h33);
    $display("timeout done");
  endtask : t_timeout
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 reset = 1'b0;
    repeat (60) @(posedge ref_clk);
    t_write();
    t_read();
    t_alert();
    t_timeout();
    stop_test();
  end
endmodule : smbus_slave_register_port_bench
bind smbsp_port smbsp_port_asserts #(.POWERUP_CYCLES(POWERUP_CYCLES),
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) smbsp_port_asserts_inst (.ref_clk, .reset, .bus_in,
  .bus_oe_n, .reg_wr, .reg_ptr, .status_any, .mask_clr, .timeout_en, .alert_mask, .alert_n);
